/* File: design/atx_pkg.sv */
package atx_pkg;
    // register byte offsets
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_RING = 12'h004;
    localparam logic [11:0] REG_AREA = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00C;
    localparam logic [11:0] REG_MASK = 12'h010;
    localparam logic [11:0] REG_CURDESC = 12'h014;
    localparam logic [11:0] REG_BYTEOFF = 12'h018;
    // status and mask bit positions
    localparam int ST_TX_INT = 0;
    localparam int ST_EMPTY = 1;
    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] RST_FLAGS = 2'h0;
    // cell layout
    localparam logic [5:0] HDR_BYTES = 6'h04;
    localparam logic [5:0] CELL_BYTES = 6'h34;
    localparam logic [7:0] HEC_POLY = 8'h07;
    localparam logic [7:0] HEC_COSET = 8'h55;
    localparam logic [7:0] EMPTY_FILL = 8'h6A;
    localparam logic [31:0] DESC_STRIDE = 32'h0000_0002;

    typedef struct packed {
        logic ready;
        logic skip;
        logic wrap;
        logic intReq;
        logic [11:0] bufOffset;
    } atx_desc_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } atx_apb_req_t;

    typedef struct packed {
        logic rd;
        logic we;
        logic [31:0] addr;
        logic [15:0] wdata;
    } atx_mem_req_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_FETCH = 3'b001,
        S_DECIDE = 3'b010,
        S_LOAD = 3'b011,
        S_SEND = 3'b100,
        S_HEC = 3'b101,
        S_RETURN = 3'b110,
        S_NEXT = 3'b111
    } atx_state_t;
endpackage

/* File: design/atx_cell_tx_queue.sv */
`timescale 1ns/1ns
// Behaviour
// R1 - descriptor halfword: ready, skip, wrap, interrupt, offset
// R2 - software keeps buffers word aligned inside area
// R3 - cell read linearly, never wrapped in area
// R4 - ready cleared after cell fully sent
// R5 - skip descriptor sends empty cell, then advances
// R6 - wrap flag returns to first ring descriptor
// R7 - interrupt flag raises event, ignored when skipping
// R8 - 52 byte buffer sent first byte first
// R9 - header error control computed and inserted
// R10 - software fills buffer before clearing skip
// R11 - start address is area base plus offset
// R12 - pointer reloaded from ring base; byte count
// R13 - unowned descriptor: empty cell, poll again
module atx_cell_tx_queue (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    input atx_pkg::atx_apb_req_t apbReq, // apb request signals
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    output atx_pkg::atx_mem_req_t memReq, // descriptor and buffer memory request
    input wire logic memAck, // memory done, one cycle
    input wire logic [15:0] memRdata, // memory read halfword
    output logic [7:0] txByte, // cell byte to phy
    output logic txValid, // cell byte valid
    input wire logic txReady, // phy takes byte
    output logic irq // level interrupt
);
    import atx_pkg::*;

    logic [31:0] ringBase_ff, nxt_ringBase;
    logic [31:0] areaBase_ff, nxt_areaBase;
    logic enable_ff, nxt_enable;
    logic [1:0] status_ff, nxt_status;
    logic [1:0] mask_ff, nxt_mask;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic irq_ff, nxt_irq;
    atx_state_t state_ff, nxt_state;
    atx_desc_t desc_ff, nxt_desc;
    logic emptyMode_ff, nxt_emptyMode;
    logic [15:0] hw_ff, nxt_hw;
    logic [5:0] cellByteOffset_ff, nxt_cellByteOffset;
    logic [31:0] currentDescPointer_ff, nxt_currentDescPointer;
    logic [7:0] hec_ff, nxt_hec;
    logic [7:0] txByte_ff, nxt_txByte;
    logic txValid_ff, nxt_txValid;
    atx_mem_req_t mem_ff, nxt_mem;
    logic txIntEvt, emptyEvt;
    logic apbSetup, apbDone, txTaken;
    logic [31:0] bufAddr;
    logic [7:0] curByte;
    logic [32:0] rdWord;

    // one step of the header check polynomial over a byte
    function automatic logic [7:0] hecStep(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ HEC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // read decode: hit bit above the data word
    function automatic logic [32:0] regRead(input logic [11:0] a);
        unique case (a)
            REG_CTRL: return {1'b1, 31'h0000_0000, enable_ff};
            REG_RING: return {1'b1, ringBase_ff};
            REG_AREA: return {1'b1, areaBase_ff};
            REG_STATUS: return {1'b1, 30'h0000_0000, status_ff};
            REG_MASK: return {1'b1, 30'h0000_0000, mask_ff};
            REG_CURDESC: return {1'b1, currentDescPointer_ff};
            REG_BYTEOFF: return {1'b1, 26'h000_0000, cellByteOffset_ff};
            default: return {1'b0, 32'h0000_0000};
        endcase
    endfunction

    assign apbSetup = apbReq.psel && !apbReq.penable;
    assign apbDone = apbReq.psel && apbReq.penable && pready_ff;
    assign rdWord = regRead(apbReq.paddr);
    assign txTaken = txValid_ff && txReady;
    // R11 R3 start address, linear read
    assign bufAddr = areaBase_ff + {18'h0_0000, desc_ff.bufOffset, 2'b00}
        + {26'h000_0000, cellByteOffset_ff};
    // R8 high byte of a halfword goes out first
    assign curByte = cellByteOffset_ff[0] ? hw_ff[7:0] : hw_ff[15:8];

    // register file and interrupt
    always_comb begin
        nxt_ringBase = ringBase_ff;
        nxt_areaBase = areaBase_ff;
        nxt_enable = enable_ff;
        nxt_mask = mask_ff;
        nxt_prdata = prdata_ff;
        nxt_pready = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_status = status_ff;
        // answer one cycle after setup, so access phase is one cycle
        if (apbSetup) begin
            nxt_pready = 1'b1;
            nxt_pslverr = !rdWord[32];
            nxt_prdata = apbReq.pwrite ? 32'h0000_0000 : rdWord[31:0];
        end
        if (apbDone && apbReq.pwrite) begin
            unique case (apbReq.paddr)
                REG_CTRL: nxt_enable = apbReq.pwdata[0];
                REG_RING: nxt_ringBase = apbReq.pwdata;
                REG_AREA: nxt_areaBase = apbReq.pwdata;
                REG_MASK: nxt_mask = apbReq.pwdata[1:0];
                default: nxt_enable = enable_ff;
            endcase
        end
        if (apbDone && !apbReq.pwrite && apbReq.paddr == REG_STATUS) begin
            // clear only what the read returned, so a setup-cycle event survives
            nxt_status = status_ff & ~prdata_ff[1:0];
        end
        // set after clear so a same-cycle event survives
        nxt_status[ST_TX_INT] = nxt_status[ST_TX_INT] | txIntEvt;
        nxt_status[ST_EMPTY] = nxt_status[ST_EMPTY] | emptyEvt;
        nxt_irq = |(status_ff & mask_ff);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ringBase_ff <= RST_WORD;
            areaBase_ff <= RST_WORD;
            enable_ff <= 1'b0;
            mask_ff <= RST_FLAGS;
            status_ff <= RST_FLAGS;
            prdata_ff <= RST_WORD;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            ringBase_ff <= nxt_ringBase;
            areaBase_ff <= nxt_areaBase;
            enable_ff <= nxt_enable;
            mask_ff <= nxt_mask;
            status_ff <= nxt_status;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            irq_ff <= nxt_irq;
        end
    end

    // descriptor walk and cell sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_desc = desc_ff;
        nxt_emptyMode = emptyMode_ff;
        nxt_hw = hw_ff;
        nxt_cellByteOffset = cellByteOffset_ff;
        nxt_currentDescPointer = currentDescPointer_ff;
        nxt_hec = hec_ff;
        nxt_txByte = txByte_ff;
        nxt_txValid = txValid_ff;
        nxt_mem = mem_ff;
        txIntEvt = 1'b0;
        emptyEvt = 1'b0;
        unique case (state_ff)
            S_IDLE: begin
                if (enable_ff) begin
                    // R12 start of ring
                    nxt_currentDescPointer = ringBase_ff;
                    nxt_state = S_FETCH;
                end
            end
            S_FETCH: begin
                // R10 descriptor re-read every visit
                if (!mem_ff.rd) begin
                    nxt_mem.rd = 1'b1;
                    nxt_mem.addr = currentDescPointer_ff;
                end else if (memAck) begin
                    nxt_mem.rd = 1'b0;
                    // R1 unpack descriptor
                    nxt_desc = atx_desc_t'(memRdata);
                    nxt_state = S_DECIDE;
                end
            end
            S_DECIDE: begin
                // R5 R13 skip or unowned sends empty
                nxt_emptyMode = desc_ff.skip || !desc_ff.ready;
                nxt_state = S_LOAD;
            end
            S_LOAD: begin
                if (emptyMode_ff) begin
                    nxt_hw = (cellByteOffset_ff < HDR_BYTES) ? 16'h0000
                        : {EMPTY_FILL, EMPTY_FILL};
                    nxt_state = S_SEND;
                end else if (!mem_ff.rd) begin
                    nxt_mem.rd = 1'b1;
                    nxt_mem.addr = bufAddr;
                end else if (memAck) begin
                    nxt_mem.rd = 1'b0;
                    nxt_hw = memRdata;
                    nxt_state = S_SEND;
                end
            end
            S_SEND: begin
                if (!txValid_ff) begin
                    nxt_txValid = 1'b1;
                    nxt_txByte = curByte;
                end else if (txTaken) begin
                    nxt_txValid = 1'b0;
                    // R12 byte count into buffer
                    nxt_cellByteOffset = cellByteOffset_ff + 6'h01;
                    // R9 accumulate over header
                    if (cellByteOffset_ff < HDR_BYTES) begin
                        nxt_hec = hecStep(hec_ff, txByte_ff);
                    end
                    // R8 ascending order, 52 buffer bytes
                    if (nxt_cellByteOffset == HDR_BYTES) begin
                        nxt_state = S_HEC;
                    end else if (nxt_cellByteOffset == CELL_BYTES) begin
                        nxt_state = S_RETURN;
                    end else if (cellByteOffset_ff[0]) begin
                        nxt_state = S_LOAD;
                    end
                end
            end
            S_HEC: begin
                // R9 inserted after header
                if (!txValid_ff) begin
                    nxt_txValid = 1'b1;
                    nxt_txByte = hec_ff ^ HEC_COSET;
                end else if (txTaken) begin
                    nxt_txValid = 1'b0;
                    nxt_state = S_LOAD;
                end
            end
            S_RETURN: begin
                if (emptyMode_ff) begin
                    emptyEvt = 1'b1;
                    nxt_state = S_NEXT;
                end else if (!mem_ff.we) begin
                    // R4 hand back with ready cleared
                    nxt_mem.we = 1'b1;
                    nxt_mem.addr = currentDescPointer_ff;
                    nxt_mem.wdata = {1'b0, desc_ff[14:0]};
                end else if (memAck) begin
                    nxt_mem.we = 1'b0;
                    // R7 only for real cells
                    txIntEvt = desc_ff.intReq;
                    nxt_state = S_NEXT;
                end
            end
            S_NEXT: begin
                nxt_cellByteOffset = 6'h00;
                nxt_hec = 8'h00;
                // R13 poll same descriptor
                if (emptyMode_ff && !desc_ff.skip) begin
                    nxt_currentDescPointer = currentDescPointer_ff;
                end else if (desc_ff.wrap) begin
                    // R6 R12 reload from ring base
                    nxt_currentDescPointer = ringBase_ff;
                end else begin
                    nxt_currentDescPointer = currentDescPointer_ff + DESC_STRIDE;
                end
                nxt_state = enable_ff ? S_FETCH : S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= S_IDLE;
            desc_ff <= atx_desc_t'(16'h0000);
            emptyMode_ff <= 1'b0;
            hw_ff <= 16'h0000;
            cellByteOffset_ff <= 6'h00;
            currentDescPointer_ff <= RST_WORD;
            hec_ff <= 8'h00;
            txByte_ff <= 8'h00;
            txValid_ff <= 1'b0;
            mem_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            desc_ff <= nxt_desc;
            emptyMode_ff <= nxt_emptyMode;
            hw_ff <= nxt_hw;
            cellByteOffset_ff <= nxt_cellByteOffset;
            currentDescPointer_ff <= nxt_currentDescPointer;
            hec_ff <= nxt_hec;
            txByte_ff <= nxt_txByte;
            txValid_ff <= nxt_txValid;
            mem_ff <= nxt_mem;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign memReq = mem_ff;
    assign txByte = txByte_ff;
    assign txValid = txValid_ff;
    assign irq = irq_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_READY_CLEARED: assert property ( // R4
        mem_ff.we |-> mem_ff.wdata == {1'b0, desc_ff[14:0]}
            && mem_ff.addr == currentDescPointer_ff)
        else $error("descriptor written back with ready still set");
    AST_SKIP_EMPTY: assert property ( // R5
        state_ff == S_DECIDE && desc_ff.skip |=> emptyMode_ff ##[1:400] !mem_ff.we
            && state_ff == S_NEXT)
        else $error("skip descriptor not sent as empty cell");
    AST_WRAP_RING: assert property ( // R6
        state_ff == S_NEXT && desc_ff.wrap && !(emptyMode_ff && !desc_ff.skip)
            |=> currentDescPointer_ff == $past(ringBase_ff))
        else $error("wrap did not return to ring base");
    AST_INT_CAUSE: assert property ( // R7
        $rose(status_ff[ST_TX_INT]) |-> $past(state_ff == S_RETURN && desc_ff.intReq
            && !emptyMode_ff && memAck))
        else $error("transmit interrupt without cause");
    AST_HEC_AFTER_HDR: assert property ( // R9
        state_ff == S_HEC && txValid_ff |-> cellByteOffset_ff == HDR_BYTES
            && txByte_ff == (hec_ff ^ HEC_COSET))
        else $error("header check byte misplaced");
    AST_BUF_ADDR: assert property ( // R11
        state_ff == S_LOAD && mem_ff.rd |-> mem_ff.addr == areaBase_ff
            + {18'h0_0000, desc_ff.bufOffset, 2'b00} + {26'h000_0000, cellByteOffset_ff})
        else $error("buffer address wrong");
    AST_BYTE_RANGE: assert property ( // R8
        cellByteOffset_ff <= CELL_BYTES && (state_ff != S_RETURN
            || cellByteOffset_ff == CELL_BYTES))
        else $error("byte count out of range");
    AST_POLL_SAME: assert property ( // R13
        state_ff == S_NEXT && emptyMode_ff && !desc_ff.skip
            |=> currentDescPointer_ff == $past(currentDescPointer_ff))
        else $error("unowned descriptor not polled again");
    AST_IRQ_LEVEL: assert property (
        ##1 irq_ff == $past(|(status_ff & mask_ff)))
        else $error("interrupt level wrong");
    AST_APB_ONE: assert property (
        apbSetup |=> pready_ff ##1 !pready_ff)
        else $error("apb answer not one cycle");

    COV_REAL_INT: cover property (txIntEvt);
    COV_SKIP: cover property (state_ff == S_NEXT && emptyMode_ff && desc_ff.skip);
    COV_WRAP: cover property (state_ff == S_NEXT && desc_ff.wrap && !emptyMode_ff);
endmodule

/* File: testbench/atx_mem_model.sv */
`timescale 1ns/1ns
module atx_mem_model (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    input atx_pkg::atx_mem_req_t memReq, // request from the engine
    output logic memAck, // one-cycle completion
    output logic [15:0] memRdata, // read halfword
    input wire logic slow, // wait states and phy stalls
    output logic txReady // phy takes a byte
);
    import atx_pkg::*;
    logic [15:0] mem [0:32767];
    logic [2:0] waitCnt;
    logic [1:0] phase;

    always @(posedge clk) begin
        phase <= phase + 2'h1;
        // slow phy takes one byte in four cycles
        txReady <= !rst && (!slow || phase == 2'h2);
        memAck <= 1'b0;
        // idle data lines toggle so a stale read shows up
        memRdata <= ~memRdata;
        if (rst) begin
            waitCnt <= 3'h0;
            phase <= 2'h0;
            memRdata <= 16'h0000;
        end else if ((memReq.rd || memReq.we) && !memAck) begin
            if (waitCnt >= (slow ? 3'h3 : 3'h0)) begin
                memAck <= 1'b1;
                waitCnt <= 3'h0;
                // address bits 15 to 1, no wrap in area
                if (memReq.we) begin
                    mem[memReq.addr[15:1]] <= memReq.wdata;
                end else begin
                    memRdata <= mem[memReq.addr[15:1]];
                end
            end else begin
                waitCnt <= waitCnt + 3'h1;
            end
        end
    end
endmodule

/* File: testbench/atx_cell_tx_queue_bench.sv */
`timescale 1ns/1ns
module atx_cell_tx_queue_bench;
    import atx_pkg::*;
    localparam logic [31:0] RING = 32'h0000_1000;
    localparam logic [31:0] AREA = 32'h0000_4000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic slow = 1'b0;
    atx_apb_req_t apbReq = '0;
    atx_mem_req_t memReq;
    logic [31:0] prdata;
    logic pready, pslverr, memAck, txValid, txReady, irq;
    logic [15:0] memRdata;
    logic [7:0] txByte;
    logic [7:0] rxQ[$];
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int cmp_count = 0;

    always #10 clk = ~clk;

    atx_cell_tx_queue atx_cell_tx_queue_i (.clk(clk), .rst(rst), .apbReq(apbReq),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .memReq(memReq),
        .memAck(memAck), .memRdata(memRdata), .txByte(txByte), .txValid(txValid),
        .txReady(txReady), .irq(irq));

    atx_mem_model atx_mem_model_i (.clk(clk), .rst(rst), .memReq(memReq), .memAck(memAck),
        .memRdata(memRdata), .slow(slow), .txReady(txReady));

    always @(posedge clk) begin
        if (txValid === 1'b1 && txReady === 1'b1) begin
            rxQ.push_back(txByte);
        end
    end

    task complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        apbReq <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) begin
            $display("ERROR at %0t: no bus answer", $time);
            n_fail++;
        end
        rd = prdata;
        err = pslverr;
        apbReq <= '0;
        @(posedge clk);
    endtask

    function atx_desc_t dsc(input logic r, s, w, i, input logic [11:0] off);
        return '{r, s, w, i, off};
    endfunction

    function logic [31:0] memAt(input logic [31:0] a);
        return {16'h0000, atx_mem_model_i.mem[a[15:1]]};
    endfunction

    task fillBuf(input logic [11:0] off, input logic [7:0] seed);
        logic [31:0] a;
        for (int k = 0; k < 52; k += 2) begin
            a = AREA + {18'h0, off, 2'b00} + 32'(k);
            atx_mem_model_i.mem[a[15:1]] = {seed + 8'(k), seed + 8'(k + 1)};
        end
    endtask

    // one cell of 53 bytes, header check byte after the header
    task checkCell(input logic empty, input logic [7:0] seed);
        logic [7:0] exp, crc, b;
        int n;
        crc = 8'h00;
        for (int i = 0; i < 53; i++) begin
            n = 0;
            while (rxQ.size() == 0 && n < 3000) begin
                @(posedge clk);
                n++;
            end
            if (rxQ.size() == 0) begin
                $display("ERROR at %0t: cell byte missing", $time);
                n_fail++;
                break;
            end
            b = rxQ.pop_front();
            if (i == 4) exp = crc ^ HEC_COSET;
            else if (empty) exp = (i < 4) ? 8'h00 : EMPTY_FILL;
            else exp = seed + 8'(i < 4 ? i : i - 1);
            if (i < 4) begin
                crc = crc ^ exp;
                for (int j = 0; j < 8; j++) begin
                    crc = crc[7] ? ({crc[6:0], 1'b0} ^ HEC_POLY) : {crc[6:0], 1'b0};
                end
            end
            chk({24'h0, b}, {24'h0, exp}); // byte order and check byte
        end
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        $display("ERROR at %0t: run too long", $time);
        n_fail++;
        complete_run;
    end

    initial begin
        fillBuf(12'h000, 8'h10); // buffer at area start
        fillBuf(12'hFFF, 8'h80); // last offset runs past area
        atx_mem_model_i.mem[RING[15:1]] = dsc(1, 0, 0, 0, 12'h000);
        atx_mem_model_i.mem[RING[15:1] + 1] = dsc(1, 1, 0, 1, 12'h010);
        atx_mem_model_i.mem[RING[15:1] + 2] = dsc(1, 0, 1, 0, 12'hFFF);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int k = 0; k < 7; k++) begin
            apb(1'b0, 12'(4 * k), 32'h0000_0000);
            chk(rd, RST_WORD);
        end
        apb(1'b0, 12'h01C, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b1, REG_RING, RING);
        apb(1'b1, REG_AREA, AREA);
        apb(1'b1, REG_MASK, 32'h0000_0001);
        apb(1'b0, REG_RING, 32'h0000_0000);
        chk(rd, RING);
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        checkCell(1'b0, 8'h10); // first descriptor cell
        checkCell(1'b1, 8'h00); // skip slot gives empty cell
        checkCell(1'b0, 8'h80); // cell past area end
        checkCell(1'b1, 8'h00); // unowned descriptor polled
        apb(1'b0, REG_CURDESC, 32'h0000_0000);
        chk(rd, RING); // pointer back at ring base
        chk(memAt(RING), {16'h0, dsc(0, 0, 0, 0, 12'h000)}); // ready handed back
        chk(memAt(RING + 2), {16'h0, dsc(1, 1, 0, 1, 12'h010)}); // no write-back
        chk(memAt(RING + 4), {16'h0, dsc(0, 0, 1, 0, 12'hFFF)});
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        chk({30'h0, rd[1:0]}, 32'h0000_0002); // only the empty event, no transmit event from skip
        chk({31'h0, irq}, 32'h0000_0000);
        // disabling lets the running cell finish
        apb(1'b1, REG_CTRL, 32'h0000_0000);
        repeat (1000) @(posedge clk);
        rxQ.delete();
        slow <= 1'b1;
        fillBuf(12'h000, 8'h20);
        fillBuf(12'h010, 8'h40); // load before releasing slot
        atx_mem_model_i.mem[RING[15:1] + 1] = dsc(1, 0, 0, 1, 12'h010);
        atx_mem_model_i.mem[RING[15:1]] = dsc(1, 0, 0, 0, 12'h000);
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        checkCell(1'b0, 8'h20); // slow memory and phy
        checkCell(1'b0, 8'h40); // released slot sends its cell
        checkCell(1'b1, 8'h00);
        chk(memAt(RING + 2), {16'h0, dsc(0, 0, 0, 1, 12'h010)});
        chk({31'h0, irq}, 32'h0000_0001); // event raises interrupt
        apb(1'b1, REG_MASK, 32'h0000_0000);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0000); // masked
        apb(1'b1, REG_MASK, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0001);
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        chk({31'h0, rd[0]}, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0000); // cleared by read
        complete_run;
    end
endmodule
